// file: apr_alert2_route.sv
// Routing mask register and drive logic of the second alert pin
`timescale 1ns/1ps
module apr_alert2_route (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Register port from the serial slave
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [apr_pkg::APR_MASK_W-1:0] reg_wdata_i,
  output logic [apr_pkg::APR_MASK_W-1:0] reg_rdata_o,
  // Alert conditions, index 0 is channel A
  input wire logic [apr_pkg::APR_NUM_CHAN-1:0] ovc_alert_i,
  input wire logic [apr_pkg::APR_NUM_CHAN-1:0] undc_alert_i,
  input wire logic [apr_pkg::APR_NUM_CHAN-1:0] ovv_alert_i,
  input wire logic [apr_pkg::APR_NUM_CHAN-1:0] undv_alert_i,
  input wire logic [apr_pkg::APR_NUM_CHAN-1:0] ovpwr_alert_i,
  input wire logic energy_acc_full_i,
  input wire logic sample_counter_full_i,
  input wire logic conversion_done_i,
  // Global enables (same bit layout) and pin function
  input wire logic [apr_pkg::APR_MASK_W-1:0] alert_enable_i,
  input wire logic pin_func_alert_i,
  // Pin drive, high means asserted
  output logic second_alert_pin_o
);
  import apr_pkg::*;

  typedef struct packed {
    logic [APR_MASK_W-1:0] mask;
    logic [APR_MASK_W-1:0] rdata;
    logic pin;
  } apr_route_st_t;

  apr_route_st_t state_ff;
  apr_route_st_t nxt_state;
  logic [APR_MASK_W-1:0] cond_vec;
  logic [APR_MASK_W-1:0] routed;
  logic hit;

  apr_pulse_if pulse_if ();

  ////////////////////////////////////////////////////////////////////////
  // Condition vector laid out like the mask
  for (genvar i = 0; i < APR_NUM_CHAN; i++) begin : g_chan
    assign cond_vec[APR_OVC_TOP-i] = ovc_alert_i[i];
    assign cond_vec[APR_UNDC_TOP-i] = undc_alert_i[i];
    assign cond_vec[APR_OVV_TOP-i] = ovv_alert_i[i];
    assign cond_vec[APR_UNDV_TOP-i] = undv_alert_i[i];
    assign cond_vec[APR_OVPWR_TOP-i] = ovpwr_alert_i[i];
  end
  assign cond_vec[APR_ENERGY_ACC_BIT] = energy_acc_full_i;
  assign cond_vec[APR_SAMPLE_CNT_BIT] = sample_counter_full_i;
  assign cond_vec[APR_CONV_DONE_BIT] = pulse_if.busy;
  assign cond_vec[0] = 1'b0;

  // Timer runs on every conversion; gating happens at the pin
  assign pulse_if.start = conversion_done_i;

  apr_conv_pulse u_conv_pulse (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pulse(pulse_if.timer)
  );

  ////////////////////////////////////////////////////////////////////////
  // Source gating: a source needs both route and global enable
  assign routed = state_ff.mask & alert_enable_i & cond_vec;
  assign hit = reg_addr_i == APR_ROUTE_ADDR;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    // Only the mask is written; status flags live elsewhere
    if (reg_wr_i && hit) begin
      nxt_state.mask = reg_wdata_i & APR_ROUTE_WMASK;
    end
    // Unmapped reads return zero
    if (reg_rd_i) begin
      nxt_state.rdata = hit ? (state_ff.mask & APR_ROUTE_WMASK) : '0;
    end
    // Registered pin keeps the output glitch-free at the cost of a cycle
    nxt_state.pin = pin_func_alert_i && (|routed);
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= '{mask: APR_ROUTE_RESET, rdata: '0, pin: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_o = state_ff.rdata;
  assign second_alert_pin_o = state_ff.pin;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_WRITE_STORES: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_wr_i && hit) |=> state_ff.mask == ($past(reg_wdata_i) & APR_ROUTE_WMASK))
    else $error("route mask not updated by write");
  AST_BIT0_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_rd_i |=> (reg_rdata_o[0] == 1'b0))
    else $error("unimplemented bit read as one");
  AST_FUNC_OFF: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !pin_func_alert_i |=> !second_alert_pin_o)
    else $error("pin asserted outside alert function");
  AST_GLOBAL_OFF: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (alert_enable_i == '0) |=> !second_alert_pin_o)
    else $error("pin asserted with all alerts disabled");
  AST_OVC_A: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && ovc_alert_i[0] && state_ff.mask[23] && alert_enable_i[23])
    |=> second_alert_pin_o)
    else $error("channel A overcurrent not routed");
  AST_UNDC_D: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && undc_alert_i[3] && state_ff.mask[16] && alert_enable_i[16])
    |=> second_alert_pin_o)
    else $error("channel D undercurrent not routed");
  AST_OVV_B: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && ovv_alert_i[1] && state_ff.mask[14] && alert_enable_i[14])
    |=> second_alert_pin_o)
    else $error("channel B overvoltage not routed");
  AST_UNDV_C: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && undv_alert_i[2] && state_ff.mask[9] && alert_enable_i[9])
    |=> second_alert_pin_o)
    else $error("channel C undervoltage not routed");
  AST_OVPWR_A: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && ovpwr_alert_i[0] && state_ff.mask[7] && alert_enable_i[7])
    |=> second_alert_pin_o)
    else $error("channel A overpower not routed");
  AST_ACC_FULL: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && energy_acc_full_i && state_ff.mask[3] && alert_enable_i[3])
    |=> second_alert_pin_o)
    else $error("accumulator fullness not routed");
  AST_CNT_FULL: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && sample_counter_full_i && state_ff.mask[2] && alert_enable_i[2])
    |=> second_alert_pin_o)
    else $error("sample counter fullness not routed");
  AST_MASK_BLOCKS: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (state_ff.mask == '0) |=> !second_alert_pin_o)
    else $error("pin asserted with empty route mask");

  // Pin is the OR of routed, enabled sources, both ways
  AST_PIN_SET: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && (|(state_ff.mask & alert_enable_i & cond_vec)))
    |=> second_alert_pin_o)
    else $error("routed enabled source did not assert pin");
  AST_PIN_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !(pin_func_alert_i && (|(state_ff.mask & alert_enable_i & cond_vec)))
    |=> !second_alert_pin_o)
    else $error("pin asserted with no routed enabled source");
  AST_CONV_ROUTED: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && pulse_if.busy && state_ff.mask[1] && alert_enable_i[1])
    |=> second_alert_pin_o)
    else $error("conversion pulse not routed");

  // Register side: mask only moves on a matching write
  AST_MASK_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !(reg_wr_i && hit) |=> $stable(state_ff.mask))
    else $error("route mask changed without a write");
  AST_READ_BACK: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_rd_i && hit) |=> (reg_rdata_o == $past(state_ff.mask)))
    else $error("route mask read back wrong");
  AST_READ_OTHER: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_rd_i && !hit) |=> (reg_rdata_o == '0))
    else $error("unmapped read returned nonzero data");
  AST_RDATA_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");

  // Far ends of each channel group, so a reversed index shows up
  AST_OVC_D: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && ovc_alert_i[3] && state_ff.mask[20] && alert_enable_i[20])
    |=> second_alert_pin_o)
    else $error("channel D overcurrent not routed");
  AST_UNDC_A: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && undc_alert_i[0] && state_ff.mask[19] && alert_enable_i[19])
    |=> second_alert_pin_o)
    else $error("channel A undercurrent not routed");
  AST_OVV_D: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && ovv_alert_i[3] && state_ff.mask[12] && alert_enable_i[12])
    |=> second_alert_pin_o)
    else $error("channel D overvoltage not routed");
  AST_UNDV_A: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && undv_alert_i[0] && state_ff.mask[11] && alert_enable_i[11])
    |=> second_alert_pin_o)
    else $error("channel A undervoltage not routed");
  AST_OVPWR_D: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_func_alert_i && ovpwr_alert_i[3] && state_ff.mask[4] && alert_enable_i[4])
    |=> second_alert_pin_o)
    else $error("channel D overpower not routed");

endmodule // apr_alert2_route

// file: apr_pkg.sv
// Constants and field layout of the second alert pin routing block
package apr_pkg;

  // Register map
  localparam logic [7:0] APR_ROUTE_ADDR = 8'h28;
  localparam int APR_MASK_W = 24;
  localparam logic [23:0] APR_ROUTE_RESET = 24'h00_0000;
  // Bit 0 is unimplemented: never stored, reads zero
  localparam logic [23:0] APR_ROUTE_WMASK = 24'hFF_FFFE;

  // Field positions (channel A sits at the highest bit of each group)
  localparam int APR_OVC_TOP = 23;
  localparam int APR_UNDC_TOP = 19;
  localparam int APR_OVV_TOP = 15;
  localparam int APR_UNDV_TOP = 11;
  localparam int APR_OVPWR_TOP = 7;
  localparam int APR_ENERGY_ACC_BIT = 3;
  localparam int APR_SAMPLE_CNT_BIT = 2;
  localparam int APR_CONV_DONE_BIT = 1;
  localparam int APR_NUM_CHAN = 4;

  // Conversion-complete pulse width
  localparam int APR_CLK_PERIOD_PS = 4000;
  localparam int APR_CONV_PULSE_PS = 5000000;
  localparam int APR_CONV_PULSE_CYC = (APR_CONV_PULSE_PS + APR_CLK_PERIOD_PS - 1)
                                      / APR_CLK_PERIOD_PS;
  localparam int APR_CNT_W = 11;
  localparam logic [10:0] APR_CNT_LAST = 11'(APR_CONV_PULSE_CYC - 1);

endpackage : apr_pkg

// file: apr_pulse_if.sv
// Handshake between the routing logic and the conversion pulse timer
`timescale 1ns/1ps
interface apr_pulse_if;
  logic start;
  logic busy;
  modport timer (input start, output busy);
  modport user (output start, input busy);
endinterface : apr_pulse_if

// file: apr_conv_pulse.sv
// Fixed-width pulse timer for the conversion-complete alert
`timescale 1ns/1ps
module apr_conv_pulse (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Trigger and status
  apr_pulse_if.timer pulse
);
  import apr_pkg::*;

  typedef enum logic {APR_P_IDLE, APR_P_HIGH} apr_pstate_t;
  typedef struct packed {
    apr_pstate_t st;
    logic [APR_CNT_W-1:0] cnt;
    logic busy;
  } apr_pulse_st_t;

  apr_pulse_st_t state_ff;
  apr_pulse_st_t nxt_state;

  ////////////////////////////////////////////////////////////////////////
  // Next state: a start while high restarts the full width
  always_comb begin
    nxt_state = state_ff;
    case (state_ff.st)
      APR_P_IDLE: begin
        if (pulse.start) begin
          nxt_state.st = APR_P_HIGH;
          nxt_state.cnt = '0;
          nxt_state.busy = 1'b1;
        end
      end
      APR_P_HIGH: begin
        if (pulse.start) begin
          nxt_state.cnt = '0; // Back-to-back conversions keep pin high
        end else if (state_ff.cnt == APR_CNT_LAST) begin
          nxt_state.st = APR_P_IDLE;
          nxt_state.busy = 1'b0;
        end else begin
          nxt_state.cnt = state_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_state.st = APR_P_IDLE;
        nxt_state.busy = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= '{st: APR_P_IDLE, cnt: '0, busy: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pulse.busy = state_ff.busy;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PULSE_WIDTH: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    $fell(state_ff.busy) |-> ($past(state_ff.cnt) == APR_CNT_LAST))
    else $error("conversion pulse ended at wrong width");
  AST_PULSE_START: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    pulse.start |=> state_ff.busy [*8])
    else $error("conversion pulse did not start");

endmodule // apr_conv_pulse

// file: apr_host_model.sv
// Host model that times the second alert pin
`timescale 1ns/1ps
module apr_host_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Watched pin and last pulse width
  input wire logic pin_i,
  output logic [15:0] width_o
);
  logic [15:0] run_ff;
  // Host only listens; width kept until next pulse ends
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_ff <= 16'h0000;
      width_o <= 16'h0000;
    end else if (pin_i) begin
      run_ff <= run_ff + 16'h0001;
    end else begin
      if (run_ff != 16'h0000) begin
        width_o <= run_ff;
      end
      run_ff <= 16'h0000;
    end
  end
endmodule // apr_host_model

// file: alert2_pin_routing_bench.sv
// Self-checking bench of the second alert pin routing block
`timescale 1ns/1ps
module alert2_pin_routing_bench;
  import apr_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [23:0] wdata = 24'h00_0000;
  logic [23:0] cond = 24'h00_0000;
  logic [23:0] en = 24'h00_0000;
  logic done = 1'b0;
  logic func = 1'b0;
  logic [23:0] rdata;
  logic pin;
  logic [15:0] width;
  logic [3:0] ovc, undc, ovv, undv, ovpwr;
  int error_cnt = 0;
  int samples_checked = 0;
  // Mask bit layout onto per-channel inputs, channel A highest
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      ovc[k] = cond[23-k];
      undc[k] = cond[19-k];
      ovv[k] = cond[15-k];
      undv[k] = cond[11-k];
      ovpwr[k] = cond[7-k];
    end
  end
  apr_alert2_route uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .ovc_alert_i(ovc), .undc_alert_i(undc), .ovv_alert_i(ovv),
    .undv_alert_i(undv), .ovpwr_alert_i(ovpwr), .energy_acc_full_i(cond[3]),
    .sample_counter_full_i(cond[2]), .conversion_done_i(done),
    .alert_enable_i(en), .pin_func_alert_i(func), .second_alert_pin_o(pin));
  apr_host_model host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .pin_i(pin), .width_o(width));
  // 250 MHz clock
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [23:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [23:0] d);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    d = rdata;
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic wait_pin(input logic lvl, input int bound);
    int n;
    n = 0;
    while (pin !== lvl) begin
      tick(1);
      n++;
      if (n > bound) begin
        error_cnt++;
        report_and_stop();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [23:0] v;
    reg_rd(APR_ROUTE_ADDR, v);
    check("mask reset", APR_ROUTE_RESET, v);
    reg_wr(APR_ROUTE_ADDR, 24'hFF_FFFF);
    reg_rd(APR_ROUTE_ADDR, v);
    check("mask all ones", 24'hFF_FFFE, v);
    reg_wr(8'h29, 24'h00_0000);
    reg_rd(APR_ROUTE_ADDR, v);
    check("foreign write", 24'hFF_FFFE, v);
    reg_rd(8'h29, v);
    check("foreign read", 24'h00_0000, v);
  endtask
  // One source at a time: routed, disabled, wrong function, masked
  task automatic test_route();
    for (int b = 2; b < 24; b++) begin
      en = 24'h00_0000;
      reg_wr(APR_ROUTE_ADDR, 24'h00_0001 << b);
      en = 24'hFF_FFFF;
      func = 1'b1;
      cond = 24'h00_0001 << b;
      tick(2);
      check("routed", 24'h00_0001, 24'(pin));
      en[b] = 1'b0;
      tick(2);
      check("disabled", 24'h00_0000, 24'(pin));
      en[b] = 1'b1;
      func = 1'b0;
      tick(2);
      check("not alert func", 24'h00_0000, 24'(pin));
      func = 1'b1;
      cond = ~(24'h00_0001 << b);
      tick(2);
      check("masked others", 24'h00_0000, 24'(pin));
      cond = 24'hFF_FFFF;
      reg_wr(APR_ROUTE_ADDR, 24'h00_0001 << b);
      tick(1);
      check("rewrite keeps", 24'h00_0001, 24'(pin));
    end
  endtask
  task automatic test_conv();
    cond = 24'h00_0000;
    en = 24'h00_0000;
    reg_wr(APR_ROUTE_ADDR, 24'h00_0002);
    en = 24'hFF_FFFF;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    wait_pin(1'b1, 4);
    wait_pin(1'b0, 2000);
    tick(2);
    check("pulse width", 24'(APR_CONV_PULSE_CYC), 24'(width));
    en[1] = 1'b0;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(3);
    check("pulse disabled", 24'h00_0000, 24'(pin));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    tick(1);
    test_regs();
    test_route();
    test_conv();
    report_and_stop();
  end
endmodule // alert2_pin_routing_bench
